// ### rtl/pin_sense.sv
/*
  Synchroniser, glitch filter and edge finder for one host pin.
  Assumes the pin is asynchronous to aclk.
*/
`timescale 1ns/1ns
`include "readout_defines.svh"
module pin_sense (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  pin_sense_if.src sense
);
  logic s1_r;
  logic s2_r;
  logic [1:0] stable_r;

  // ----------------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= `PIN_RESET;
      s2_r <= `PIN_RESET;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
    end
  end

  // ----------------------------------------------------------------------
  // Glitch filter and edges
  // ----------------------------------------------------------------------
  // A new level is accepted only after it has been seen FILT_CYC cycles.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stable_r <= 2'h0;
      sense.lvl <= `PIN_RESET;
      sense.rise <= 1'b0;
      sense.fall <= 1'b0;
    end else begin
      sense.rise <= 1'b0;
      sense.fall <= 1'b0;
      if (s2_r == sense.lvl) begin
        stable_r <= 2'h0;
      end else if (stable_r == `FILT_CYC - 2'h1) begin
        stable_r <= 2'h0;
        sense.lvl <= s2_r;
        sense.rise <= s2_r;
        sense.fall <= ~s2_r;
      end else begin
        stable_r <= stable_r + 2'h1;
      end
    end
  end
endmodule

// ### rtl/pin_sense_if.sv
/*
  Filtered level and edge pulses of one host pin.
  Assumes the producer and consumer share one clock.
*/
`timescale 1ns/1ns
interface pin_sense_if;
  logic lvl;
  logic rise;
  logic fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface

// ### rtl/readout_defines.svh
/*
  Offsets, field positions, reset values and timing counts of the status
  readout block. Assumes a 250 MHz core clock.
*/
`ifndef READOUT_DEFINES_SVH
`define READOUT_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_STATE 8'h08
`define REG_SNAP 8'h0C
`define CTRL_RESET 32'h0000_0001
`define CTRL_RD_EN_BIT 0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// Status word layout
// ----------------------------------------------------------------------
`define BIT_LOC_WAKE 0
`define BIT_REM_WAKE 1
`define BIT_RSVD 2
`define BIT_ERR_LO 4
`define BIT_ERR_HI 10
`define BIT_ERR_SUM 11
`define BIT_WAKE_SRC 12
`define BIT_EN_IND 13
`define BIT_STB_IND 14
`define BIT_PARITY 15
`define LAST_BIT 4'hF
`define STORE_MASK 16'h17FB

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_NS 4
`define EN_WIN_MIN_NS 8
`define EN_WIN_MAX_NS 2000
`define EN_TIMEOUT_NS 4000
`define EN_WIN_MIN_CYC ((`EN_WIN_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define EN_WIN_MAX_CYC (`EN_WIN_MAX_NS / `CLK_NS)
`define EN_TIMEOUT_CYC ((`EN_TIMEOUT_NS + `CLK_NS - 1) / `CLK_NS)
`define FILT_CYC 2'h2
`define PIN_RESET 1'b1

`endif

// ### rtl/readout_pkg.sv
/*
  Types shared by the status readout block.
  Assumes nothing of its surroundings.
*/
package readout_pkg;

  // Actual operating mode reported by the device core.
  typedef enum logic [2:0] {
    full_operation_mode = 3'b000,
    listen_only_mode = 3'b001,
    standby_low_power_mode = 3'b010,
    sleep_entry_command = 3'b011,
    deep_sleep_mode = 3'b100
  } op_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT_FALL = 3'b001,
    ST_WAIT_RISE = 3'b010,
    ST_SHIFT = 3'b011
  } rd_state_e;

endpackage

// ### rtl/status_readout.sv
/*
  Status register with serial readout over the mode enable pin and status
  signalling on the active-low fault output, plus an AXI4-Lite slave.
  Assumes the device core supplies the actual mode, set events and cause
  levels on aclk, and that the host pins are asynchronous.
*/
// How it works
// - Read-only status word, shifted by enable pin.
// - Busy output blocks mode changes during readout.
// - No readout without host supply in range.
// - Readout in normal, listen, standby modes only.
// - Permission taken from actual mode, not pins.
// - Enable clocks, fault pin carries data.
// - Normal starts on fall, others on rise.
// - Next edge must fall inside edge window.
// - No edge before timeout: exit, apply command.
// - Listen/standby need extra fall before enable.
// - Each fall shifts next bit, bit 0 first.
// - Set bit shows low, clear shows high.
// - Low power select ignored while shifting.
// - Enable idle past timeout ends readout now.
// - Bits latched; clear only if cause gone.
// - Clear on normal entry or full pass.
// - Partial readout clears nothing.
// - Wrap to bit 0 with cleared contents.
// - Idle fault pin shows per-command summary.
// - Fault selection follows pins, not mode.
// - Fault level derived from latched bits.
// - Sixteen active-low bits in fixed layout.
`timescale 1ns/1ns
`include "readout_defines.svh"
module status_readout (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mode_enable_pin,
  input wire logic low_power_select_pin,
  input wire logic host_io_reference_supply,
  input wire logic [2:0] mode_cur,
  input wire logic normal_entered,
  input wire logic [15:0] event_set,
  input wire logic [15:0] cause_active,
  output logic fault_out_pin,
  output logic readout_busy,
  output logic mode_apply,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  pin_sense_if en_s ();
  pin_sense_if stb_s ();
  readout_pkg::rd_state_e state_r;
  logic sup1_r;
  logic sup_ok_r;
  logic [15:0] set_r;
  logic [15:0] snap_r;
  logic [15:0] word_now;
  logic [3:0] idx_r;
  logic [11:0] cnt_r;
  logic reload_r;
  logic rd_en_r;
  logic allowed;
  logic init_go;
  logic edge_any;
  logic last_fall;
  logic clr_go;
  logic in_win;
  logic timed_out;
  logic cur_bit;
  logic aw_have_r;
  logic w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;

  pin_sense u_en (.aclk(aclk), .aresetn(aresetn), .pin(mode_enable_pin), .sense(en_s));
  pin_sense u_stb (.aclk(aclk), .aresetn(aresetn), .pin(low_power_select_pin), .sense(stb_s));

  // ----------------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------------
  // Builds the active-low word from the latched flags and pin levels.
  function automatic logic [15:0] make_word(input logic [15:0] s, input logic en,
                                            input logic stb);
    logic [15:0] w;
    w = ~(s & `STORE_MASK);
    w[`BIT_RSVD] = 1'b1;
    w[`BIT_ERR_SUM] = ~|s[`BIT_ERR_HI:`BIT_ERR_LO];
    w[`BIT_EN_IND] = en;
    w[`BIT_STB_IND] = stb;
    w[`BIT_PARITY] = ^w[14:0];
    return w;
  endfunction

  assign word_now = make_word(set_r, en_s.lvl, stb_s.lvl);
  assign cur_bit = snap_r[idx_r];

  // Flags stay set until a clear finds their cause gone; a new event wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      set_r <= 16'h0000;
    end else if (clr_go) begin
      set_r <= ((set_r & cause_active) | event_set) & `STORE_MASK;
    end else begin
      set_r <= (set_r | event_set) & `STORE_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // Readout sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sup1_r <= 1'b0;
      sup_ok_r <= 1'b0;
    end else begin
      sup1_r <= host_io_reference_supply;
      sup_ok_r <= sup1_r;
    end
  end

  always_comb begin
    allowed = sup_ok_r && rd_en_r;
    case (mode_cur)
      readout_pkg::full_operation_mode,
      readout_pkg::listen_only_mode,
      readout_pkg::standby_low_power_mode: allowed = allowed;
      default: allowed = 1'b0;
    endcase
  end

  // Falling edge starts under the normal command, rising edge otherwise.
  assign init_go = allowed && (state_r == readout_pkg::ST_IDLE) &&
                   ((en_s.fall && stb_s.lvl) || en_s.rise);
  assign edge_any = en_s.rise || en_s.fall;
  assign in_win = (cnt_r >= 12'(`EN_WIN_MIN_CYC)) && (cnt_r <= 12'(`EN_WIN_MAX_CYC));
  assign timed_out = cnt_r >= 12'(`EN_TIMEOUT_CYC);
  assign last_fall = (state_r == readout_pkg::ST_SHIFT) && en_s.fall &&
                     (idx_r == `LAST_BIT);
  assign clr_go = normal_entered || last_fall;

  // Counts cycles since the last enable edge, saturating.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 12'h000;
    end else if (init_go || edge_any) begin
      cnt_r <= 12'h000;
    end else if (!timed_out) begin
      cnt_r <= cnt_r + 12'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= readout_pkg::ST_IDLE;
      mode_apply <= 1'b0;
    end else begin
      mode_apply <= 1'b0;
      case (state_r)
        readout_pkg::ST_IDLE: begin
          if (init_go && en_s.fall) begin
            state_r <= readout_pkg::ST_WAIT_RISE;
          end else if (init_go) begin
            state_r <= readout_pkg::ST_WAIT_FALL;
          end
        end
        readout_pkg::ST_WAIT_FALL, readout_pkg::ST_WAIT_RISE: begin
          if (!allowed || timed_out || (edge_any && !in_win)) begin
            state_r <= readout_pkg::ST_IDLE;
            mode_apply <= 1'b1;
          end else if (en_s.fall) begin
            state_r <= readout_pkg::ST_WAIT_RISE;
          end else if (en_s.rise) begin
            state_r <= readout_pkg::ST_SHIFT;
          end
        end
        readout_pkg::ST_SHIFT: begin
          if (!allowed || timed_out) begin
            state_r <= readout_pkg::ST_IDLE;
            mode_apply <= 1'b1;
          end
        end
        default: state_r <= readout_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      readout_busy <= 1'b0;
    end else begin
      readout_busy <= init_go || (state_r != readout_pkg::ST_IDLE &&
                      !(mode_apply == 1'b0 && state_r == readout_pkg::ST_IDLE));
    end
  end

  // Snapshot at enable keeps one pass consistent; reload after a wrap.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snap_r <= 16'hFFFF;
      idx_r <= 4'h0;
      reload_r <= 1'b0;
    end else begin
      reload_r <= last_fall;
      if (state_r != readout_pkg::ST_SHIFT && en_s.rise) begin
        snap_r <= word_now;
        idx_r <= 4'h0;
      end else if (reload_r) begin
        snap_r <= word_now;
      end
      if (state_r == readout_pkg::ST_SHIFT && en_s.fall) begin
        idx_r <= idx_r + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Fault output
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_out_pin <= 1'b1;
    end else if (state_r == readout_pkg::ST_SHIFT) begin
      if (en_s.fall) begin
        fault_out_pin <= cur_bit;
      end
    end else if (stb_s.lvl && en_s.lvl) begin
      fault_out_pin <= word_now[`BIT_ERR_SUM];
    end else if (stb_s.lvl) begin
      if (set_r[`BIT_LOC_WAKE] || set_r[`BIT_REM_WAKE]) begin
        fault_out_pin <= word_now[`BIT_WAKE_SRC];
      end else begin
        fault_out_pin <= word_now[`BIT_ERR_SUM];
      end
    end else begin
      fault_out_pin <= ~(set_r[`BIT_LOC_WAKE] || set_r[`BIT_REM_WAKE]);
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
    end else begin
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (aw_have_r && w_have_r) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
      end else if (aw_have_r && w_have_r) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // Only byte lane 0 of the control word holds a writable bit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      rd_en_r <= 1'(`CTRL_RESET);
    end else if (aw_have_r && w_have_r) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr_r == `REG_CTRL) begin
        s_axi_bresp <= `RESP_OKAY;
        if (s_axi_wstrb[0]) begin
          rd_en_r <= w_data_r[`CTRL_RD_EN_BIT];
        end
      end else begin
        s_axi_bresp <= `RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (s_axi_araddr)
          `REG_CTRL: s_axi_rdata <= {31'h0, rd_en_r};
          `REG_STATUS: s_axi_rdata <= {16'h0, word_now};
          `REG_STATE: s_axi_rdata <= {23'h0, readout_busy, idx_r, 1'b0, state_r};
          `REG_SNAP: s_axi_rdata <= {16'h0, snap_r};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_last_bit;
    state_r == readout_pkg::ST_SHIFT && en_s.fall && idx_r == `LAST_BIT;
  endsequence

  sequence s_exit;
    state_r == readout_pkg::ST_IDLE && mode_apply;
  endsequence

  property p_no_supply;
    @(posedge aclk) disable iff (!aresetn)
    !sup_ok_r && state_r == readout_pkg::ST_IDLE |=> state_r == readout_pkg::ST_IDLE;
  endproperty
  a_no_supply: assert property (p_no_supply) else $error("readout began without supply");

  property p_sleep_block;
    @(posedge aclk) disable iff (!aresetn)
    mode_cur == readout_pkg::deep_sleep_mode && state_r == readout_pkg::ST_IDLE
    |=> state_r == readout_pkg::ST_IDLE;
  endproperty
  a_sleep_block: assert property (p_sleep_block) else $error("readout began in sleep");

  property p_shift_bit;
    @(posedge aclk) disable iff (!aresetn)
    state_r == readout_pkg::ST_SHIFT && en_s.fall |=> fault_out_pin == $past(cur_bit);
  endproperty
  a_shift_bit: assert property (p_shift_bit) else $error("wrong bit shifted out");

  property p_full_clear;
    @(posedge aclk) disable iff (!aresetn)
    s_last_bit |-> clr_go ##1 idx_r == 4'h0 ##1 snap_r == $past(word_now);
  endproperty
  a_full_clear: assert property (p_full_clear) else $error("full pass did not clear");

  property p_only_clear;
    @(posedge aclk) disable iff (!aresetn)
    !clr_go |=> (($past(set_r) & ~set_r) == 16'h0000);
  endproperty
  a_only_clear: assert property (p_only_clear) else $error("flag lost without clear");

  property p_timeout;
    @(posedge aclk) disable iff (!aresetn)
    state_r == readout_pkg::ST_SHIFT && timed_out |=> s_exit;
  endproperty
  a_timeout: assert property (p_timeout) else $error("idle enable did not end readout");

  property p_early_edge;
    @(posedge aclk) disable iff (!aresetn)
    state_r == readout_pkg::ST_WAIT_RISE && edge_any && cnt_r < 12'(`EN_WIN_MIN_CYC)
    |=> s_exit;
  endproperty
  a_early_edge: assert property (p_early_edge) else $error("early edge accepted");

  property p_busy_start;
    @(posedge aclk) disable iff (!aresetn)
    init_go |=> readout_busy [*2];
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not raised");

  property p_idle_normal;
    @(posedge aclk) disable iff (!aresetn)
    state_r == readout_pkg::ST_IDLE && stb_s.lvl && en_s.lvl
    |=> fault_out_pin == $past(word_now[`BIT_ERR_SUM]);
  endproperty
  a_idle_normal: assert property (p_idle_normal) else $error("fault pin wrong idle");
endmodule

// ### verif/host_model.sv
/*
  Host model that drives the two mode pins and samples the fault pin.
  Assumes the caller starts each task just after a rising edge of aclk.
*/
`timescale 1ns/1ns
module host_model (
  output logic mode_enable_pin,
  output logic low_power_select_pin,
  input wire logic fault_out_pin
);
  initial begin
    mode_enable_pin = 1'b1;
    low_power_select_pin = 1'b1;
  end

  task automatic set_pins(input logic stb, input logic en);
    #1;
    low_power_select_pin = stb;
    mode_enable_pin = en;
  endtask

  // A short low pulse checks that glitches do not start a readout.
  task automatic pulse_low(input int ns);
    #1 mode_enable_pin = 1'b0;
    #(ns) mode_enable_pin = 1'b1;
  endtask

  // The link clock runs only inside a readout, with a 32 ns period.
  task automatic readout(input logic rise_init, input int nfalls, output logic [31:0] bits);
    bits = '0;
    #1;
    if (rise_init) begin
      mode_enable_pin = 1'b1;
      #16 mode_enable_pin = 1'b0;
      #16 mode_enable_pin = 1'b1;
    end else begin
      mode_enable_pin = 1'b0;
      #16 mode_enable_pin = 1'b1;
    end
    for (int i = 0; i < nfalls; i++) begin
      #((i == 0) ? 16 : 2) mode_enable_pin = 1'b0;
      #16 mode_enable_pin = 1'b1;
      #14 bits[i] = fault_out_pin;
    end
    if (rise_init) begin
      #16 mode_enable_pin = 1'b0;
    end
  endtask
endmodule

// ### verif/status_readout_tb.sv
/*
  Self-checking bench of the status readout block.
  Assumes the host model drives the pins and the bench plays the device core.
*/
`timescale 1ns/1ns
`include "readout_defines.svh"
module status_readout_tb;
  typedef struct {logic stb; logic en; logic [15:0] ev; logic exp;} row_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic mode_enable_pin;
  logic low_power_select_pin;
  logic host_io_reference_supply = 1'b1;
  logic [2:0] mode_cur = 3'h0;
  logic normal_entered = 1'b0;
  logic [15:0] event_set = 16'h0000;
  logic [15:0] cause_active = 16'h0000;
  logic fault_out_pin;
  logic readout_busy;
  logic mode_apply;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  int n_fail = 0;
  int tests_run = 0;
  logic [31:0] bits;
  logic [31:0] rd;
  logic [1:0] resp;
  logic [15:0] ew;
  row_s rows [0:10] = '{'{1'b1, 1'b1, 16'h0000, 1'b1}, '{1'b1, 1'b1, 16'h0020, 1'b0},
    '{1'b1, 1'b1, 16'h0001, 1'b1}, '{1'b1, 1'b0, 16'h0040, 1'b0}, '{1'b1, 1'b0, 16'h0000, 1'b1},
    '{1'b1, 1'b0, 16'h0011, 1'b1}, '{1'b1, 1'b0, 16'h1002, 1'b0}, '{1'b0, 1'b1, 16'h0001, 1'b0},
    '{1'b0, 1'b1, 16'h0080, 1'b1}, '{1'b0, 1'b0, 16'h0002, 1'b0}, '{1'b0, 1'b0, 16'h0000, 1'b1}};

  always #2 aclk = ~aclk;

  status_readout dut (.aclk(aclk), .aresetn(aresetn), .mode_enable_pin(mode_enable_pin),
    .low_power_select_pin(low_power_select_pin),
    .host_io_reference_supply(host_io_reference_supply), .mode_cur(mode_cur),
    .normal_entered(normal_entered), .event_set(event_set), .cause_active(cause_active),
    .fault_out_pin(fault_out_pin), .readout_busy(readout_busy), .mode_apply(mode_apply),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  host_model host (.mode_enable_pin(mode_enable_pin),
    .low_power_select_pin(low_power_select_pin), .fault_out_pin(fault_out_pin));

  // ----------------------------------------------------------------------
  // Compare, bus and helper tasks
  // ----------------------------------------------------------------------
  task automatic check_bit(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h", $time, msg, got);
    end
  endtask

  task automatic test_done;
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 50 && !done; k++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    check_bit(done, 1'b1, "write answer missing");
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    r = 2'h3;
    d = '0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 50 && !done; k++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    check_bit(done, 1'b1, "read answer missing");
  endtask

  task automatic pulse_flags(input logic [15:0] ev, input logic clr);
    @(posedge aclk);
    event_set <= ev;
    normal_entered <= clr;
    @(posedge aclk);
    event_set <= 16'h0000;
    normal_entered <= 1'b0;
  endtask

  task automatic wait_apply(input int lo, input int hi);
    int cnt;
    cnt = 0;
    while (mode_apply !== 1'b1 && cnt < 1200) begin
      @(posedge aclk);
      cnt++;
    end
    check_bit(cnt >= lo && cnt <= hi, 1'b1, "exit delay");
    @(posedge aclk);
    check_bit(readout_busy, 1'b0, "busy after exit");
  endtask

  task automatic try_refused(input int ns, input string msg);
    repeat (8) @(posedge aclk);
    host.pulse_low(ns);
    repeat (20) @(posedge aclk);
    check_bit(readout_busy, 1'b0, msg);
  endtask

  task automatic read_status(input logic [15:0] exp);
    axi_read(`REG_STATUS, rd, resp);
    check_word(rd, {16'h0000, exp}, "status word");
  endtask

  function automatic logic [15:0] exp_word(input logic [15:0] set, input logic en,
                                           input logic stb);
    logic [15:0] w;
    w = ~set & `STORE_MASK;
    w[`BIT_RSVD] = 1'b1;
    w[`BIT_ERR_SUM] = ~|set[`BIT_ERR_HI:`BIT_ERR_LO];
    w[`BIT_EN_IND] = en;
    w[`BIT_STB_IND] = stb;
    w[`BIT_PARITY] = ^w[14:0];
    return w;
  endfunction

  // Four readout timeouts and the table take about 20 us; this is ample.
  initial begin
    #300000;
    n_fail++;
    test_done();
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    check_bit(fault_out_pin, 1'b1, "fault pin after reset");
    check_bit(readout_busy, 1'b0, "busy after reset");
    axi_read(`REG_CTRL, rd, resp);
    check_word(rd, `CTRL_RESET, "control reset");
    read_status(exp_word(16'h0000, 1'b1, 1'b1));
    axi_write(`REG_STATUS, 32'h0000_0000, resp);
    check_word({30'h0, resp}, {30'h0, `RESP_SLVERR}, "status write");
    read_status(exp_word(16'h0000, 1'b1, 1'b1));
    axi_read(8'h10, rd, resp);
    check_word({30'h0, resp}, {30'h0, `RESP_SLVERR}, "unmapped read");
    mode_cur <= readout_pkg::deep_sleep_mode;
    for (int i = 0; i < 11; i++) begin
      pulse_flags(16'h0000, 1'b1);
      pulse_flags(rows[i].ev, 1'b0);
      host.set_pins(rows[i].stb, rows[i].en);
      repeat (12) @(posedge aclk);
      check_bit(fault_out_pin, rows[i].exp, "idle fault pin");
      check_bit(readout_busy, 1'b0, "readout in sleep");
      read_status(exp_word(rows[i].ev, rows[i].en, rows[i].stb));
    end
    host.set_pins(1'b1, 1'b1);
    repeat (12) @(posedge aclk);
    mode_cur <= readout_pkg::full_operation_mode;
    cause_active <= 16'h0020;
    pulse_flags(16'h0021, 1'b0);
    repeat (8) @(posedge aclk);
    host.readout(1'b0, 32, bits);
    check_bit(readout_busy, 1'b1, "busy in readout");
    ew = exp_word(16'h0021, 1'b1, 1'b1);
    check_word({16'h0, bits[15:0]}, {16'h0, ew}, "first pass");
    ew = exp_word(16'h0020, 1'b1, 1'b1);
    check_word({19'h0, bits[28:16]}, {19'h0, ew[12:0]}, "second pass");
    wait_apply(980, 1015);
    read_status(exp_word(16'h0020, 1'b1, 1'b1));
    mode_cur <= readout_pkg::deep_sleep_mode;
    host.set_pins(1'b1, 1'b0);
    repeat (12) @(posedge aclk);
    cause_active <= 16'h0000;
    mode_cur <= readout_pkg::listen_only_mode;
    pulse_flags(16'h0010, 1'b0);
    repeat (8) @(posedge aclk);
    host.readout(1'b1, 5, bits);
    ew = exp_word(16'h0010, 1'b1, 1'b1);
    check_word({27'h0, bits[4:0]}, {27'h0, ew[4:0]}, "partial pass");
    wait_apply(980, 1015);
    read_status(exp_word(16'h0030, 1'b0, 1'b1));
    pulse_flags(16'h0000, 1'b1);
    read_status(exp_word(16'h0000, 1'b0, 1'b1));
    mode_cur <= readout_pkg::deep_sleep_mode;
    host.set_pins(1'b0, 1'b0);
    repeat (12) @(posedge aclk);
    mode_cur <= readout_pkg::standby_low_power_mode;
    pulse_flags(16'h1002, 1'b0);
    repeat (8) @(posedge aclk);
    host.readout(1'b1, 16, bits);
    ew = exp_word(16'h1002, 1'b1, 1'b0);
    check_word({16'h0, bits[15:0]}, {16'h0, ew}, "standby pass");
    wait_apply(980, 1015);
    read_status(exp_word(16'h0000, 1'b0, 1'b0));
    mode_cur <= readout_pkg::deep_sleep_mode;
    host.set_pins(1'b1, 1'b1);
    repeat (12) @(posedge aclk);
    host_io_reference_supply <= 1'b0;
    mode_cur <= readout_pkg::full_operation_mode;
    try_refused(16, "readout without supply");
    host_io_reference_supply <= 1'b1;
    mode_cur <= readout_pkg::sleep_entry_command;
    try_refused(16, "readout in sleep entry");
    mode_cur <= readout_pkg::full_operation_mode;
    axi_write(`REG_CTRL, 32'h0000_0000, resp);
    try_refused(16, "readout disabled");
    axi_write(`REG_CTRL, `CTRL_RESET, resp);
    try_refused(4, "glitch start");
    host.set_pins(1'b1, 1'b0);
    repeat (10) @(posedge aclk);
    check_bit(readout_busy, 1'b1, "fall start");
    wait_apply(980, 1015);
    test_done();
  end
endmodule
